// ===== hw/t2cc_regs.svh
`ifndef T2CC_REGS_SVH
`define T2CC_REGS_SVH
`define T2CC_ADDR_CTRL 8'h00
`define T2CC_ADDR_CHCFG 8'h04
`define T2CC_ADDR_COUNT 8'h08
`define T2CC_ADDR_RELOAD 8'h0c
`define T2CC_ADDR_CC0 8'h10
`define T2CC_ADDR_STATUS 8'h20
`define T2CC_ADDR_MASK 8'h24
`define T2CC_MC_LAST 4'hb
`define T2CC_CNT_MAX 16'hffff
`define T2CC_CNT_ONE 16'h0001
`define T2CC_CH_LEVEL 8
`define T2CC_CH_EDGE 12
`define T2CC_ST_OVF 0
`define T2CC_ST_EXEV 1
`define T2CC_ST_MATCH 2
`define T2CC_ST_PIN 6
`define T2CC_ST_W 10
`endif

// ===== hw/t2cc_pkg.sv
package t2cc_pkg;
  // Count source selection
  typedef enum logic [1:0] {
    T2CC_IN_STOP = 2'b00,
    T2CC_IN_TIMER = 2'b01,
    T2CC_IN_COUNTER = 2'b10,
    T2CC_IN_GATED = 2'b11
  } t2cc_insel_e;
  // Per-channel function
  typedef enum logic [1:0] {
    T2CC_CH_OFF = 2'b00,
    T2CC_CH_CAP = 2'b01,
    T2CC_CH_CMP0 = 2'b10,
    T2CC_CH_CMP1 = 2'b11
  } t2cc_chmode_e;
  // Control register layout, bit 0 upward: inSel, prescale, reloadEn, reloadPin, captureSw
  typedef struct packed {
    logic captureSw;
    logic reloadPin;
    logic reloadEn;
    logic prescale;
    t2cc_insel_e inSel;
  } t2cc_ctrl_s;
endpackage

// ===== hw/t2cc_top.sv
`include "t2cc_regs.svh"
module t2cc_top
  import t2cc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic countGateInputPin,
  input wire logic reloadTriggerPin,
  input wire logic [3:0] capcmpPinIn,
  output logic [3:0] capcmpPinOut,
  output logic [3:0] capcmpPinOe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] byteMerge(logic [15:0] old, logic [15:0] wd,
                                            logic [1:0] strb);
    byteMerge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction
  // Aligned word inside the register map
  function automatic logic mapped(logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `T2CC_ADDR_MASK);
  endfunction

  t2cc_ctrl_s ctrl_reg;
  logic [3:0][1:0] chMode_reg;
  logic [3:0] cmpLevel_reg;
  logic [3:0] pinEdge_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [15:0] cc_reg [4];
  logic [`T2CC_ST_W-1:0] status_reg;
  logic [`T2CC_ST_W-1:0] mask_reg;
  logic [`T2CC_ST_W-1:0] statusSet;
  logic gateSync1, gateSync2, gatePrev, trigSync1, trigSync2, trigPrev;
  logic [3:0] ccSync1, ccSync2, ccPrev;
  logic [3:0] divCnt;
  logic mcTick, preTog, stepDone;
  logic setup, wrEn, cntWr, cntEvt, countStep, ovf, trigFall, reloadPinEv, ccSel;
  logic [15:0] maskMerged, clrMask;
  logic [3:0] ccEdge, pinIrq, capPin, capSw, ccWr, match;
  logic [31:0] rdMux;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, then the last synced level for edge detection
  // History is not reset: it follows the idle pin level, so no false edge after reset
  always_ff @(posedge clk)
  begin
    gateSync1 <= countGateInputPin;
    gateSync2 <= gateSync1;
    trigSync1 <= reloadTriggerPin;
    trigSync2 <= trigSync1;
    ccSync1 <= capcmpPinIn;
    ccSync2 <= ccSync1;
    trigPrev <= trigSync2;
    ccPrev <= ccSync2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle: one tick every twelve clocks
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      divCnt <= '0;
      mcTick <= 1'b0;
    end
    else
    begin
      mcTick <= (divCnt == `T2CC_MC_LAST);
      divCnt <= (divCnt == `T2CC_MC_LAST) ? '0 : divCnt + 4'h1;
    end
  end
  // Count pin sampled once per machine cycle, so falling edges need two of them
  always_ff @(posedge clk)
  begin
    if (srst)
      gatePrev <= 1'b0;
    else if (mcTick)
      gatePrev <= gateSync2;
  end
  // Raw count event by source
  always_comb
  begin
    unique case (ctrl_reg.inSel)
      T2CC_IN_STOP: cntEvt = 1'b0;
      T2CC_IN_TIMER: cntEvt = mcTick;
      T2CC_IN_COUNTER: cntEvt = mcTick & gatePrev & ~gateSync2;
      T2CC_IN_GATED: cntEvt = mcTick & gateSync2;
    endcase
  end
  // Divide-by-two prescaler
  always_ff @(posedge clk)
  begin
    if (srst)
      preTog <= 1'b0;
    else if (cntEvt)
      preTog <= ~preTog;
  end

  assign countStep = cntEvt & (~ctrl_reg.prescale | preTog);
  assign ovf = countStep & (count_reg == `T2CC_CNT_MAX);
  assign trigFall = trigPrev & ~trigSync2;
  assign reloadPinEv = trigFall & ctrl_reg.reloadEn & ctrl_reg.reloadPin;
  assign ccEdge = ccPrev ^ ccSync2;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; no wait states, read data comes from a flop loaded in the setup phase
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pready & pwrite & mapped(paddr);
  assign cntWr = wrEn & (paddr == `T2CC_ADDR_COUNT);
  assign ccSel = paddr[7:4] == 4'(`T2CC_ADDR_CC0 >> 4);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped(paddr);
      prdata <= (setup & ~pwrite & mapped(paddr)) ? rdMux : '0;
    end
  end
  // Read mux; reserved bits read zero, refused addresses are masked above
  always_comb
  begin
    rdMux = '0;
    case (paddr)
      `T2CC_ADDR_CTRL: rdMux[$bits(t2cc_ctrl_s)-1:0] = ctrl_reg;
      `T2CC_ADDR_CHCFG: rdMux[15:0] = {pinEdge_reg, cmpLevel_reg, chMode_reg};
      `T2CC_ADDR_COUNT: rdMux[15:0] = count_reg;
      `T2CC_ADDR_RELOAD: rdMux[15:0] = reload_reg;
      `T2CC_ADDR_STATUS: rdMux[`T2CC_ST_W-1:0] = status_reg;
      `T2CC_ADDR_MASK: rdMux[`T2CC_ST_W-1:0] = mask_reg;
      default:
        if (ccSel)
          rdMux[15:0] = cc_reg[paddr[3:2]];
    endcase
  end
  // Configuration; everything off after reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_reg <= '0;
      chMode_reg <= '0;
      cmpLevel_reg <= '0;
      pinEdge_reg <= '0;
      reload_reg <= '0;
      mask_reg <= '0;
    end
    else if (wrEn)
    begin
      if (paddr == `T2CC_ADDR_CTRL && pstrb[0])
        ctrl_reg <= pwdata[$bits(t2cc_ctrl_s)-1:0];
      if (paddr == `T2CC_ADDR_CHCFG)
      begin
        if (pstrb[0])
          chMode_reg <= pwdata[7:0];
        if (pstrb[1])
          {pinEdge_reg, cmpLevel_reg} <= pwdata[15:8];
      end
      if (paddr == `T2CC_ADDR_RELOAD)
        reload_reg <= byteMerge(reload_reg, pwdata[15:0], pstrb[1:0]);
      if (paddr == `T2CC_ADDR_MASK)
        mask_reg <= maskMerged[`T2CC_ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; a software write wins over the trigger, the trigger over counting
  always_ff @(posedge clk)
  begin
    if (srst)
      count_reg <= '0;
    else if (cntWr)
      count_reg <= byteMerge(count_reg, pwdata[15:0], pstrb[1:0]);
    else if (reloadPinEv)
      count_reg <= reload_reg;
    else if (countStep)
      count_reg <= (ovf && ctrl_reg.reloadEn && !ctrl_reg.reloadPin) ? reload_reg
                 : count_reg + `T2CC_CNT_ONE;
  end
  // Compare looks at the count one cycle after each step
  always_ff @(posedge clk)
  begin
    if (srst)
      stepDone <= 1'b0;
    else
      stepDone <= countStep;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel capture, compare and pin interrupt terms
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      capPin[i] = (chMode_reg[i] == T2CC_CH_CAP) & ~ctrl_reg.captureSw & ccEdge[i];
      capSw[i] = (chMode_reg[i] == T2CC_CH_CAP) & ctrl_reg.captureSw;
      ccWr[i] = wrEn & ccSel & (paddr[3:2] == 2'(i));
      match[i] = stepDone & chMode_reg[i][1] & (count_reg == cc_reg[i]);
      pinIrq[i] = pinEdge_reg[i] ? (~ccPrev[i] & ccSync2[i])
                : (ccPrev[i] & ~ccSync2[i]);
    end
  end
  // Capture/compare registers; a pin capture beats a simultaneous write
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (srst)
        cc_reg[i] <= '0;
      else if (capPin[i])
        cc_reg[i] <= count_reg;
      else if (ccWr[i])
        cc_reg[i] <= (capSw[i] && pstrb[0]) ? count_reg
                   : byteMerge(cc_reg[i], pwdata[15:0], pstrb[1:0]);
    end
  end
  // Compare pins; driven only while the channel compares
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      capcmpPinOut <= '0;
      capcmpPinOe <= '0;
    end
    else
      for (int i = 0; i < 4; i++)
      begin
        capcmpPinOe[i] <= chMode_reg[i][1];
        if (match[i])
          capcmpPinOut[i] <= (chMode_reg[i] == T2CC_CH_CMP0) ? 1'b1
                           : cmpLevel_reg[i];
        else if (ovf && chMode_reg[i] == T2CC_CH_CMP0)
          capcmpPinOut[i] <= 1'b0;
      end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    statusSet = '0;
    statusSet[`T2CC_ST_OVF] = ovf;
    statusSet[`T2CC_ST_EXEV] = trigFall;
    statusSet[`T2CC_ST_MATCH +: 4] = match;
    statusSet[`T2CC_ST_PIN +: 4] = pinIrq;
  end
  // Lane-merged write data for the mask and for the write-one-to-clear
  assign maskMerged = byteMerge(16'(mask_reg), pwdata[15:0], pstrb[1:0]);
  assign clrMask = byteMerge(16'h0000, pwdata[15:0], pstrb[1:0]);
  always_ff @(posedge clk)
  begin
    if (srst)
      status_reg <= '0;
    else if (wrEn && paddr == `T2CC_ADDR_STATUS)
      status_reg <= (status_reg & ~clrMask[`T2CC_ST_W-1:0]) | statusSet;
    else
      status_reg <= status_reg | statusSet;
  end
  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_tick_rate;
    countStep |=> !countStep [*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("count stepped faster than a machine cycle");
  property p_gate_hold;
    (ctrl_reg.inSel == T2CC_IN_GATED && !gateSync2) |-> !countStep;
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gated timer counted with gate low");
  property p_reload_ovf;
    (ovf && ctrl_reg.reloadEn && !ctrl_reg.reloadPin && !cntWr && !reloadPinEv)
      |=> count_reg == $past(reload_reg);
  endproperty
  a_reload_ovf: assert property (p_reload_ovf)
    else $error("overflow reload missed");
  property p_reload_pin;
    (reloadPinEv && !cntWr) |=> count_reg == $past(reload_reg) && status_reg[`T2CC_ST_EXEV];
  endproperty
  a_reload_pin: assert property (p_reload_pin)
    else $error("trigger reload or flag missed");
  // Channel 2 is the one that the capture scenarios drive
  property p_cap_pin;
    capPin[2] |=> cc_reg[2] == $past(count_reg);
  endproperty
  a_cap_pin: assert property (p_cap_pin)
    else $error("pin capture missed");
  property p_cap_sw;
    (ccWr[2] && capSw[2] && pstrb[0] && !capPin[2]) |=> cc_reg[2] == $past(count_reg);
  endproperty
  a_cap_sw: assert property (p_cap_sw)
    else $error("software capture missed");
  property p_cmp0;
    (match[0] && chMode_reg[0] == T2CC_CH_CMP0)
      |=> capcmpPinOut[0] && status_reg[`T2CC_ST_MATCH];
  endproperty
  a_cmp0: assert property (p_cmp0)
    else $error("compare mode 0 output or flag wrong");
  property p_cmp1;
    (ovf && !match[1] && chMode_reg[1] == T2CC_CH_CMP1) |=> $stable(capcmpPinOut[1]);
  endproperty
  a_cmp1: assert property (p_cmp1)
    else $error("overflow changed compare mode 1 output");
  property p_irq;
    (ovf && mask_reg[`T2CC_ST_OVF]) |=> status_reg[`T2CC_ST_OVF] ##1 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("overflow did not raise interrupt");

endmodule

// ===== testbench/t2cc_pin_model.sv
module t2cc_pin_model
(
  input wire logic clk,
  input wire logic [3:0] capcmpPinOut,
  input wire logic [3:0] capcmpPinOe,
  input wire logic [3:0] extLevel,
  output logic [3:0] capcmpPinIn,
  output logic gatePin,
  output logic trigPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sources idle high until told to act
  initial
  begin
    gatePin = 1'b1;
    trigPin = 1'b1;
  end
  // Wire level: the device wins where it drives
  assign capcmpPinIn = (capcmpPinOe & capcmpPinOut) | (~capcmpPinOe & extLevel);
  ////////////////////////////////////////////////////////////////
  // Each level held 30 clocks, margin over the sync delay
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (30) @(posedge clk);
      gatePin <= 1'b0;
      repeat (30) @(posedge clk);
      gatePin <= 1'b1;
    end
  endtask
  // One falling edge on the trigger, then idle again
  task automatic trigFall;
    trigPin <= 1'b0;
    repeat (30) @(posedge clk);
    trigPin <= 1'b1;
  endtask
  // Park the count/gate pin at one level
  task automatic gateLevel(input logic v);
    gatePin <= v;
  endtask
endmodule

// ===== testbench/t2cc_tb_top.sv
`include "t2cc_regs.svh"
module t2cc_tb_top
  import t2cc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] extLevel = 4'hf;
  logic sawHigh = 1'b0;
  logic pready, pslverr, irq, gatePin, trigPin, err;
  logic [31:0] prdata, rd;
  logic [3:0] pinIn, pinOut, pinOe;
  int failures = 0;
  int checkCount = 0;
  int cycles = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  t2cc_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countGateInputPin(gatePin), .reloadTriggerPin(trigPin),
    .capcmpPinIn(pinIn), .capcmpPinOut(pinOut), .capcmpPinOe(pinOe), .irq(irq));
  t2cc_pin_model farSide (.clk(clk), .capcmpPinOut(pinOut), .capcmpPinOe(pinOe),
    .extLevel(extLevel), .capcmpPinIn(pinIn), .gatePin(gatePin), .trigPin(trigPin));
  // Compare output seen high between match and overflow
  always @(posedge clk)
    if (pinOut[0] === 1'b1)
      sawHigh <= 1'b1;
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      failures++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; an extra edge after release avoids a same-step re-raise
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Run the source for a fixed time, then stop and read the count
  task automatic rateRun(input logic [31:0] ctrl, input int lo, input int hi);
    wr(`T2CC_ADDR_COUNT, 32'h0);
    wr(`T2CC_ADDR_CTRL, ctrl);
    repeat (240) @(posedge clk);
    wr(`T2CC_ADDR_CTRL, 32'h0);
    apb(1'b0, `T2CC_ADDR_COUNT, 32'h0);
    chk(32'(rd >= lo && rd <= hi), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk(`T2CC_ADDR_CTRL, 32'h0);
    rdchk(`T2CC_ADDR_CHCFG, 32'h0);
    rdchk(8'h30, 32'h0);
    chk(err, 1'b1);
    $display("reset test done");
    rateRun(32'h1, 19, 21);
    rateRun(32'h5, 9, 11);
    wr(`T2CC_ADDR_COUNT, 32'h0);
    wr(`T2CC_ADDR_CTRL, 32'h2);
    farSide.pulses(5);
    wr(`T2CC_ADDR_CTRL, 32'h0);
    rdchk(`T2CC_ADDR_COUNT, 32'h5);
    // Gated timer: machine rate with the gate high, frozen with it low
    rateRun(32'h3, 19, 21);
    farSide.gateLevel(1'b0);
    rateRun(32'h3, 0, 0);
    farSide.gateLevel(1'b1);
    $display("rate test done");
    // Ch0 compare mode 0, ch1 compare mode 1 driving high, ch2 capture
    wr(`T2CC_ADDR_CHCFG, 32'h021e);
    wr(`T2CC_ADDR_CC0, 32'hfff0);
    wr(`T2CC_ADDR_CC0 + 8'h04, 32'hfff0);
    wr(`T2CC_ADDR_COUNT, 32'hffe0);
    wr(`T2CC_ADDR_RELOAD, 32'h1234);
    wr(`T2CC_ADDR_MASK, 32'h1);
    wr(`T2CC_ADDR_STATUS, 32'h3ff);
    chk(pinOe, 4'h3);
    wr(`T2CC_ADDR_CTRL, 32'h9);
    for (int i = 0; i < 600 && irq !== 1'b1; i++)
      @(posedge clk);
    wr(`T2CC_ADDR_CTRL, 32'h0);
    rdchk(`T2CC_ADDR_COUNT, 32'h1234);
    chk(sawHigh, 1'b1);
    chk(pinOut[1:0], 2'b10);
    rdchk(`T2CC_ADDR_STATUS, 32'h04d);
    chk(irq, 1'b1);
    wr(`T2CC_ADDR_STATUS, 32'h3ff);
    @(posedge clk); // Interrupt output lags the status by one cycle
    chk(irq, 1'b0);
    $display("compare test done");
    // Capture on a pin edge, then by software write
    wr(`T2CC_ADDR_COUNT, 32'h0abc);
    extLevel[2] <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(`T2CC_ADDR_CC0 + 8'h08, 32'h0abc);
    rdchk(`T2CC_ADDR_STATUS, 32'h100);
    wr(`T2CC_ADDR_CTRL, 32'h20);
    wr(`T2CC_ADDR_COUNT, 32'h0777);
    wr(`T2CC_ADDR_CC0 + 8'h08, 32'h5555);
    rdchk(`T2CC_ADDR_CC0 + 8'h08, 32'h0777);
    $display("capture test done");
    // Reload on the trigger pin, event flag unmasked
    wr(`T2CC_ADDR_CTRL, 32'h18);
    wr(`T2CC_ADDR_MASK, 32'h2);
    farSide.trigFall();
    rdchk(`T2CC_ADDR_COUNT, 32'h1234);
    rdchk(`T2CC_ADDR_STATUS, 32'h102);
    chk(irq, 1'b1);
    $display("reload test done");
    end_of_test;
  end
endmodule
